// ==== verilog/pps_pkg.sv ====
// Purpose: Constants for the probe pin control and silicon revision register bank.
// Assumes: Registers sit on 32-bit AXI4-Lite words at four times their index.
// Notes: Every offset, and the probe control field positions and value after reset, live here; the revision fields and value come from pps_top.

package pps_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int PPS_ADDR_W = 12;
   localparam int PPS_DATA_W = 32;

   // ---------------------------------------------------------------
   // Register indices and byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] PPS_IDX_PROBE_CTRL = 8'h47;
   localparam logic [7:0] PPS_IDX_REVISION = 8'h7F;
   localparam logic [PPS_ADDR_W-1:0] PPS_ADDR_PROBE_CTRL = {2'b00, PPS_IDX_PROBE_CTRL, 2'b00};
   localparam logic [PPS_ADDR_W-1:0] PPS_ADDR_REVISION = {2'b00, PPS_IDX_REVISION, 2'b00};

   // ---------------------------------------------------------------
   // Field layout and values after reset
   // ---------------------------------------------------------------
   localparam int PPS_FAST_SLEW_BIT = 7;
   localparam int PPS_SEL_LSB = 0;
   localparam int PPS_SEL_W = 4;
   localparam logic [7:0] PPS_PROBE_CTRL_RST = 8'h00;

   // ---------------------------------------------------------------
   // Probe source selector codes
   // ---------------------------------------------------------------
   localparam logic [3:0] PPS_SEL_TRI0 = 4'h0;
   localparam logic [3:0] PPS_SEL_TRI1 = 4'h1;
   localparam logic [3:0] PPS_SEL_LOW = 4'h2;
   localparam logic [3:0] PPS_SEL_HIGH = 4'h3;
   localparam logic [3:0] PPS_SEL_TX_ENV = 4'h4;
   localparam logic [3:0] PPS_SEL_TX_ACT = 4'h5;
   localparam logic [3:0] PPS_SEL_SECURE = 4'h6;
   localparam logic [3:0] PPS_SEL_RX_ENV = 4'h7;
   localparam logic [3:0] PPS_SEL_RX_ACT = 4'h8;
   localparam logic [3:0] PPS_SEL_RX_BIT = 4'h9;

   // ---------------------------------------------------------------
   // AXI responses
   // ---------------------------------------------------------------
   localparam logic [1:0] PPS_RESP_OKAY = 2'h0;
   localparam logic [1:0] PPS_RESP_DECERR = 2'h3;

   // ---------------------------------------------------------------
   // Channel states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PPS_WR_COLLECT = 2'b00,
      PPS_WR_COMMIT = 2'b01,
      PPS_WR_RESP = 2'b10
   } pps_wr_state_t;

   typedef enum logic [0:0] {
      PPS_RD_IDLE = 1'b0,
      PPS_RD_RESP = 1'b1
   } pps_rd_state_t;

endpackage

// ==== verilog/pps_probe_mux.sv ====
// Purpose: Registered source selection and drive enable for the probe output pin.
// Assumes: All source signals are synchronous to sys_clk.
// Notes: Pin value and enable change one edge after the selector or a source changes.

`timescale 1ns/10ps

module pps_probe_mux (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [3:0] sel,
   input wire logic tx_envelope,
   input wire logic tx_active,
   input wire logic secure_module_serial_signal,
   input wire logic rx_envelope,
   input wire logic rx_active,
   input wire logic rx_bit,
   output logic pin_out,
   output logic pin_oe
);

   // ---------------------------------------------------------------
   // Selection
   // ---------------------------------------------------------------
   logic next_out;
   logic next_oe;

   assign next_oe = (sel >= pps_pkg::PPS_SEL_LOW) && (sel <= pps_pkg::PPS_SEL_RX_BIT);

   assign next_out =
      (sel == pps_pkg::PPS_SEL_LOW) ? 1'b0 :
      (sel == pps_pkg::PPS_SEL_HIGH) ? 1'b1 :
      (sel == pps_pkg::PPS_SEL_TX_ENV) ? tx_envelope :
      (sel == pps_pkg::PPS_SEL_TX_ACT) ? tx_active :
      (sel == pps_pkg::PPS_SEL_SECURE) ? secure_module_serial_signal :
      (sel == pps_pkg::PPS_SEL_RX_ENV) ? rx_envelope :
      (sel == pps_pkg::PPS_SEL_RX_ACT) ? rx_active :
      (sel == pps_pkg::PPS_SEL_RX_BIT) ? rx_bit :
      1'b0;

   // ---------------------------------------------------------------
   // Output flops
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_out <= next_out;
         pin_oe <= next_oe;
      end
   end

endmodule // pps_probe_mux

// ==== verilog/pps_top.sv ====
// Purpose: Probe pin control and silicon revision registers behind an AXI4-Lite slave.
// Assumes: One clock; source signals and bus inputs are synchronous to sys_clk.
// Notes: One write and one read may be under way at the same time, each on its own path.
//
// Local design decision: the AXI4-Lite slave port.

`timescale 1ns/10ps

module pps_top #(
   // Arbitrary value, not tied to any real part.
   parameter logic [3:0] REV_MAJOR = 4'h1,
   // Arbitrary value, not tied to any real part.
   parameter logic [3:0] REV_MINOR = 4'h0
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [pps_pkg::PPS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [pps_pkg::PPS_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pps_pkg::PPS_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [pps_pkg::PPS_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tx_envelope,
   input wire logic tx_active,
   input wire logic secure_module_serial_signal,
   input wire logic rx_envelope,
   input wire logic rx_active,
   input wire logic rx_bit,
   output logic probe_output_pin_out,
   output logic probe_output_pin_oe,
   output logic fast_slew_enable
);

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // Returns 2'b01 for the control word, 2'b10 for revision, 2'b00 when unmapped.
   function automatic logic [1:0] pps_decode(input logic [pps_pkg::PPS_ADDR_W-1:0] addr);
      logic [1:0] hit;
      logic [pps_pkg::PPS_ADDR_W-3:0] word_idx;
      hit = 2'b00;
      word_idx = addr[pps_pkg::PPS_ADDR_W-1:2];
      if (word_idx == pps_pkg::PPS_ADDR_PROBE_CTRL[pps_pkg::PPS_ADDR_W-1:2]) begin
         hit = 2'b01;
      end else if (word_idx == pps_pkg::PPS_ADDR_REVISION[pps_pkg::PPS_ADDR_W-1:2]) begin
         hit = 2'b10;
      end
      return hit;
   endfunction

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [pps_pkg::PPS_SEL_W-1:0] probe_source_select;
   logic [7:0] probe_pin_control;
   logic [7:0] silicon_revision;

   assign probe_pin_control = {fast_slew_enable, 3'b000, probe_source_select};
   assign silicon_revision = {REV_MAJOR, REV_MINOR};

   // ---------------------------------------------------------------
   // Write channel
   // ---------------------------------------------------------------
   pps_pkg::pps_wr_state_t wr_state;
   pps_pkg::pps_wr_state_t next_wr_state;
   logic [pps_pkg::PPS_ADDR_W-1:0] wr_addr;
   logic [7:0] wr_byte;
   logic wr_lane0;
   logic aw_take;
   logic w_take;
   logic aw_done;
   logic w_done;
   logic [1:0] wr_hit;
   logic do_write;
   logic ctrl_write;

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign wr_hit = pps_decode(wr_addr);
   assign do_write = (wr_state == pps_pkg::PPS_WR_COMMIT);
   assign ctrl_write = do_write && (wr_hit == 2'b01) && wr_lane0;

   always_comb begin
      next_wr_state = wr_state;
      case (wr_state)
         pps_pkg::PPS_WR_COLLECT: begin
            if ((aw_done || aw_take) && (w_done || w_take)) begin
               next_wr_state = pps_pkg::PPS_WR_COMMIT;
            end
         end
         pps_pkg::PPS_WR_COMMIT: begin
            next_wr_state = pps_pkg::PPS_WR_RESP;
         end
         pps_pkg::PPS_WR_RESP: begin
            if (s_axi_bready) begin
               next_wr_state = pps_pkg::PPS_WR_COLLECT;
            end
         end
         default: begin
            next_wr_state = pps_pkg::PPS_WR_COLLECT;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wr_state <= pps_pkg::PPS_WR_COLLECT;
      end else begin
         wr_state <= next_wr_state;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         aw_done <= 1'b0;
         s_axi_awready <= 1'b1;
         wr_addr <= '0;
      end else if (aw_take) begin
         aw_done <= 1'b1;
         s_axi_awready <= 1'b0;
         wr_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_done <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         w_done <= 1'b0;
         s_axi_wready <= 1'b1;
         wr_byte <= 8'h00;
         wr_lane0 <= 1'b0;
      end else if (w_take) begin
         w_done <= 1'b1;
         s_axi_wready <= 1'b0;
         wr_byte <= s_axi_wdata[7:0];
         wr_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_done <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pps_pkg::PPS_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_hit == 2'b00) ? pps_pkg::PPS_RESP_DECERR : pps_pkg::PPS_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         fast_slew_enable <= pps_pkg::PPS_PROBE_CTRL_RST[pps_pkg::PPS_FAST_SLEW_BIT];
         probe_source_select <= pps_pkg::PPS_PROBE_CTRL_RST[pps_pkg::PPS_SEL_W-1:0];
      end else if (ctrl_write) begin
         fast_slew_enable <= wr_byte[pps_pkg::PPS_FAST_SLEW_BIT];
         probe_source_select <= wr_byte[pps_pkg::PPS_SEL_LSB +: pps_pkg::PPS_SEL_W];
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   pps_pkg::pps_rd_state_t rd_state;
   logic ar_take;
   logic [1:0] rd_hit;
   logic [pps_pkg::PPS_DATA_W-1:0] rd_word;

   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign rd_hit = pps_decode(s_axi_araddr);
   assign rd_word = (rd_hit == 2'b01) ? {24'h000000, probe_pin_control} :
                    (rd_hit == 2'b10) ? {24'h000000, silicon_revision} :
                    32'h00000000;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rd_state <= pps_pkg::PPS_RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= pps_pkg::PPS_RESP_OKAY;
      end else begin
         case (rd_state)
            pps_pkg::PPS_RD_IDLE: begin
               if (ar_take) begin
                  rd_state <= pps_pkg::PPS_RD_RESP;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= rd_word;
                  s_axi_rresp <= (rd_hit == 2'b00) ? pps_pkg::PPS_RESP_DECERR :
                                 pps_pkg::PPS_RESP_OKAY;
               end
            end
            pps_pkg::PPS_RD_RESP: begin
               if (s_axi_rready) begin
                  rd_state <= pps_pkg::PPS_RD_IDLE;
                  s_axi_arready <= 1'b1;
                  s_axi_rvalid <= 1'b0;
               end
            end
            default: begin
               rd_state <= pps_pkg::PPS_RD_IDLE;
               s_axi_arready <= 1'b1;
               s_axi_rvalid <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Probe pin
   // ---------------------------------------------------------------
   pps_probe_mux u_probe_mux (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .sel(probe_source_select),
      .tx_envelope(tx_envelope),
      .tx_active(tx_active),
      .secure_module_serial_signal(secure_module_serial_signal),
      .rx_envelope(rx_envelope),
      .rx_active(rx_active),
      .rx_bit(rx_bit),
      .pin_out(probe_output_pin_out),
      .pin_oe(probe_output_pin_oe)
   );

endmodule // pps_top

// ==== dv/pps_properties.sv ====
// Purpose: Port assertions for the probe pin and revision bank.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/10ps
module pps_properties #(
   parameter logic [3:0] REV_MAJOR = 4'h1,
   parameter logic [3:0] REV_MINOR = 4'h0
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic probe_output_pin_out,
   input wire logic probe_output_pin_oe,
   input wire logic fast_slew_enable
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   chk_slew_by_write: assert property (
      $changed(fast_slew_enable) |-> !$past(s_axi_awready)) else $error("Slew moved alone.");
   chk_slew_readback: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_awready
      && s_axi_araddr == pps_pkg::PPS_ADDR_PROBE_CTRL |=> s_axi_rdata[7] == fast_slew_enable)
      else $error("Slew bit read wrong.");
   chk_oe_by_write: assert property (
      $changed(probe_output_pin_oe) |-> !$past(s_axi_awready)) else $error("Pin enable moved.");
   chk_idle_pin_low: assert property (
      !probe_output_pin_oe |-> !probe_output_pin_out) else $error("Pin high while released.");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("Read answer late.");
   chk_read_holds: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped.");
   chk_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##[1:2] s_axi_bvalid) else $error("Write answer wrong.");
   chk_rev_value: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == pps_pkg::PPS_ADDR_REVISION
      |=> s_axi_rdata == {24'h0, REV_MAJOR, REV_MINOR}) else $error("Revision read wrong.");
   chk_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("Upper read bits set.");
endmodule // pps_properties

bind pps_top pps_properties #(.REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR)) u_pps_properties (
   .sys_clk(sys_clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .probe_output_pin_out(probe_output_pin_out),
   .probe_output_pin_oe(probe_output_pin_oe), .fast_slew_enable(fast_slew_enable));

// ==== dv/pps_top_test.sv ====
// Purpose: Self-checking bench for the probe pin and revision bank.
// Assumes: 250 MHz clock, reset held four cycles.
// Notes: Registers are reached through AXI4-Lite master tasks.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module pps_top_test;
   localparam logic [3:0] MAJ = 4'h1;
   localparam logic [3:0] MIN = 4'h0;
   localparam logic [11:0] CTRL = pps_pkg::PPS_ADDR_PROBE_CTRL;
   localparam logic [11:0] REV = pps_pkg::PPS_ADDR_REVISION;
   localparam logic [1:0] OK = pps_pkg::PPS_RESP_OKAY;
   localparam logic [1:0] DEC = pps_pkg::PPS_RESP_DECERR;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic probe_output_pin_out, probe_output_pin_oe, fast_slew_enable;
   logic [5:0] srcs = 6'h0;
   int fail_count = 0, num_checks = 0, cycles = 0;

   pps_top #(.REV_MAJOR(MAJ), .REV_MINOR(MIN)) u_pps_top (
      .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_envelope(srcs[0]),
      .tx_active(srcs[1]), .secure_module_serial_signal(srcs[2]), .rx_envelope(srcs[3]),
      .rx_active(srcs[4]), .rx_bit(srcs[5]), .probe_output_pin_out(probe_output_pin_out),
      .probe_output_pin_oe(probe_output_pin_oe), .fast_slew_enable(fast_slew_enable));

   always #2 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
         input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge sys_clk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er,
         input string nm);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `CHK(nm, ed, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
   endtask

   task automatic t_regs();
      rd(CTRL, 32'h0, OK, "ctrl_rst");
      rd(REV, {24'h0, MAJ, MIN}, OK, "rev");
      wr(REV, 32'h55, 4'hF, OK);
      rd(REV, {24'h0, MAJ, MIN}, OK, "rev_ro");
      wr(CTRL, 32'hFF, 4'hF, OK);
      `CHK("slew_on", 1'b1, fast_slew_enable)
      rd(CTRL, 32'h8F, OK, "ctrl_rsv");
      wr(CTRL, 32'h0, 4'h0, OK);
      rd(CTRL, 32'h8F, OK, "ctrl_strb");
      wr(CTRL, 32'h7F, 4'h1, OK);
      `CHK("slew_off", 1'b0, fast_slew_enable)
      wr(12'h0, 32'h1, 4'h1, DEC);
      rd(12'h0, 32'h0, DEC, "unmapped");
   endtask

   task automatic pin(input logic [3:0] c, input logic v);
      logic eo, ev;
      eo = (c >= 4'h2) && (c <= 4'h9);
      ev = (c == 4'h3) || (eo && c >= 4'h4 && v);
      @(posedge sys_clk);
      srcs <= (eo && c >= 4'h4) ? ({6{~v}} ^ (6'h1 << (c - 4'h4))) : {6{v}};
      repeat (3) @(posedge sys_clk);
      `CHK("pin_oe", eo, probe_output_pin_oe)
      `CHK("pin_out", ev, probe_output_pin_out)
   endtask

   task automatic t_select();
      for (int c = 0; c < 16; c++) begin
         wr(CTRL, 32'(c), 4'h1, OK);
         pin(4'(c), 1'b0);
         pin(4'(c), 1'b1);
      end
   endtask

   initial begin
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      t_regs();
      t_select();
      test_done();
   end
endmodule // pps_top_test
